// ===== verilog/csc_pkg.sv
/*
  Shared constants for the CPU-side control block: register map, field
  positions, reset values, cycle encodings and the CPU reset pulse length.
  Assumes a single 250 MHz clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package csc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SLEEP = 8'h04;
  localparam logic [7:0] ADDR_PORTA = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_INTEN = 8'h10;
  localparam logic [7:0] ADDR_INTCLR = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  // Field positions
  localparam int CTRL_MISS_BIT = 0;
  localparam int SLEEP_PIN_BIT = 7;
  localparam int PORTA_SWRST_BIT = 0;
  localparam int INT_RESET = 0;
  localparam int INT_FPUERR = 1;
  localparam int INT_SHUTDOWN = 2;
  localparam int INT_HOLD = 3;
  localparam int INT_W = 4;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SLEEP_RST = 8'h80;
  // Synchronised pin vector layout and idle levels
  localparam int SY_CHRDY = 0;
  localparam int SY_BUSY = 1;
  localparam int SY_ERR = 2;
  localparam int SY_PEREQ = 3;
  localparam int SY_DMA_HOLD_REQUEST_IN = 4;
  localparam int SY_BUS_RESET_DRIVE_IN = 5;
  localparam int SY_KBDRC = 6;
  localparam int SY_MISS = 7;
  localparam int SY_W = 8;
  localparam logic [7:0] SY_IDLE = 8'h87;
  // I/O ports and special cycle byte enables
  localparam logic [15:0] PORT_RESET = 16'h00EF;
  localparam logic [15:0] PORT_FPU_CLR = 16'h00F0;
  localparam logic [15:0] PORT_FPU_RST = 16'h00F1;
  localparam logic [3:0] BE_SHUTDOWN = 4'hE;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int RESET_PULSE_NS = 64;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_CNT_W = 5;
  // Cycle type from memory/io, data/code, write/read
  typedef enum logic [2:0] {
    CSC_CYC_INTA = 3'b000,
    CSC_CYC_SPECIAL = 3'b001,
    CSC_CYC_IORD = 3'b010,
    CSC_CYC_IOWR = 3'b011,
    CSC_CYC_CODE = 3'b100,
    CSC_CYC_RSVD = 3'b101,
    CSC_CYC_MEMRD = 3'b110,
    CSC_CYC_MEMWR = 3'b111
  } csc_cycle_t;
endpackage
`default_nettype wire

// ===== verilog/csc_sync.sv
/*
  Three-stage synchroniser for a vector of pin inputs. A bit's output
  changes only once the second and third stages agree.
  Assumes inputs are asynchronous to clk; one clock, synchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] syncOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } csc_sync_state_t;

  csc_sync_state_t q;
  csc_sync_state_t d;

  // Stage one feeds only stage two, so no logic sees a metastable value
  always_comb
  begin
    d = q;
    d.s1 = pinIn;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        d.val[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= '{s1: IDLE, s2: IDLE, s3: IDLE, val: IDLE};
    end
    else
    begin
      q <= d;
    end
  end

  assign syncOut = q.val;
endmodule
`default_nettype wire

// ===== verilog/csc_cycle_decode.sv
/*
  Combinational decode of a CPU bus cycle: cycle type, shutdown and the
  I/O port hits that steer reset and coprocessor handling.
  Assumes inputs are stable while the address strobe is low.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_cycle_decode (
  input wire logic memOrIo,
  input wire logic dataOrCode,
  input wire logic writeOrRead,
  input wire logic [3:0] byteEnN,
  input wire logic [15:2] cpuAddr,
  output csc_pkg::csc_cycle_t cycType,
  output logic isShutdown,
  output logic hitReset,
  output logic hitFpuClr,
  output logic hitFpuRst
);
  // Byte address of the lowest enabled lane compared with a port number
  function automatic logic portHit(input logic [15:2] a, input logic [3:0] be,
                                   input logic [15:0] port);
    logic [1:0] lane;
    lane = 2'h3;
    if (!be[0])
      lane = 2'h0;
    else if (!be[1])
      lane = 2'h1;
    else if (!be[2])
      lane = 2'h2;
    portHit = ({a, lane} == port);
  endfunction

  // Status pins form the cycle code directly
  assign cycType = csc_pkg::csc_cycle_t'({memOrIo, dataOrCode, writeOrRead});
  assign isShutdown = (cycType == csc_pkg::CSC_CYC_SPECIAL)
                      && (byteEnN == csc_pkg::BE_SHUTDOWN);
  assign hitReset = (cycType == csc_pkg::CSC_CYC_IORD)
                    && portHit(cpuAddr, byteEnN, csc_pkg::PORT_RESET);
  assign hitFpuClr = (cycType == csc_pkg::CSC_CYC_IOWR)
                     && portHit(cpuAddr, byteEnN, csc_pkg::PORT_FPU_CLR);
  assign hitFpuRst = (cycType == csc_pkg::CSC_CYC_IOWR)
                     && portHit(cpuAddr, byteEnN, csc_pkg::PORT_FPU_RST);
endmodule
`default_nettype wire

// ===== verilog/csc_cpu_side.sv
/*
  CPU-side control: cycle decode and start, ready merge, hold handshake,
  CPU reset pulse, coprocessor busy/error/request relay, sleep/miss pin,
  AHB-Lite register slave with a level interrupt.
  Assumes clk is the looped-back double-frequency clock, that the CPU,
  loop-back ready and channel status pins share that clock, and that
  the other pins are asynchronous.
*/
// Summary of operation
// - Classify cycle from data/code and memory/io
// - Low address strobe starts cycle, samples command
// - All state clocked by loop-back clock
// - Oscillator reproduced as CPU double clock out
// - Pin mirrors sleep bit7; control bit0 makes miss
// - Ready out is DRAM ready OR channel ready during slot cycles
// - Low ready input completes current cycle
// - Hold request from DMA request or refresh
// - Pulse CPU reset on five reset sources
// - Coprocessor error output low during CPU reset
// - Busy follows coprocessor, latched after error
// - Operand request forced after error until F0h
// - RAM write strobe low only on writes
// - Upper address copies forced low under hold
// - Write/read select decoded into cycle type
`timescale 1ns/100ps
`default_nettype none
module csc_cpu_side (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic oscDoubleFreqIn,
  output logic cpuDoubleClockOut,
  input wire logic addrStrobeN,
  input wire logic dataOrCode,
  input wire logic memOrIo,
  input wire logic writeOrRead,
  input wire logic [3:0] byteEnN,
  input wire logic [15:2] cpuAddr,
  input wire logic [2:0] upperAddr,
  output logic [2:0] upperAddrInt,
  input wire logic readyInN,
  output logic readyOutN,
  input wire logic dramReady,
  input wire logic slotCycle,
  input wire logic channelReadyN,
  input wire logic holdAck,
  output logic holdRequest,
  input wire logic dmaHoldRequestIn,
  input wire logic coupledRefreshReq,
  input wire logic channelStatus1ReadN,
  input wire logic channelStatus0WriteN,
  output logic memReadN,
  output logic ramWriteN,
  output logic cpuResetOut,
  input wire logic busResetDriveIn,
  input wire logic kbdResetCmdIn,
  input wire logic fpuErrorInN,
  input wire logic fpuBusyInN,
  input wire logic fpuOperandRequestIn,
  output logic cpuFpuErrorN,
  output logic cpuFpuBusyN,
  output logic cpuOperandRequest,
  input wire logic sleepOrMissPinIn,
  output logic sleepOrMissPinOut,
  output logic sleepOrMissPinOe,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] sleep;
    logic [csc_pkg::INT_W-1:0] status;
    logic [csc_pkg::INT_W-1:0] inten;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
    logic cycActive;
    csc_pkg::csc_cycle_t cycType;
    logic slotCyc;
    logic readyOutN;
    logic memRdN;
    logic ramWrN;
    logic [2:0] upperInt;
    logic holdReq;
    logic [csc_pkg::RST_CNT_W-1:0] rstCnt;
    logic busyLatch;
    logic pereqForced;
    logic busyOutN;
    logic errOutN;
    logic pereqOut;
    logic rstdrvPrev;
    logic kbdPrev;
    logic hldaPrev;
  } csc_ctl_state_t;

  localparam int RST_HI_LAST = csc_pkg::RESET_PULSE_CYC - 1;

  csc_ctl_state_t q;
  csc_ctl_state_t d;
  logic [csc_pkg::SY_W-1:0] syncPins;
  csc_pkg::csc_cycle_t decType;
  logic decShutdown;
  logic decReset;
  logic decFpuClr;
  logic decFpuRst;
  logic busTake;
  logic cycStart;
  logic swReset;
  logic resetEvt;
  logic fpuClear;
  logic shutdownEvt;
  logic fpuBusy;
  logic fpuErr;

  // Asynchronous pins pass four flops before use (three stages plus the output register)
  csc_sync #(.W(csc_pkg::SY_W), .IDLE(csc_pkg::SY_IDLE)) uSync (
    .clk(clk),
    .rst_b(rst_b),
    .pinIn({sleepOrMissPinIn, kbdResetCmdIn, busResetDriveIn, dmaHoldRequestIn,
            fpuOperandRequestIn, fpuErrorInN, fpuBusyInN, channelReadyN}),
    .syncOut(syncPins)
  );

  // Cycle classification from the status pins
  csc_cycle_decode uDecode (
    .memOrIo(memOrIo),
    .dataOrCode(dataOrCode),
    .writeOrRead(writeOrRead),
    .byteEnN(byteEnN),
    .cpuAddr(cpuAddr),
    .cycType(decType),
    .isShutdown(decShutdown),
    .hitReset(decReset),
    .hitFpuClr(decFpuClr),
    .hitFpuRst(decFpuRst)
  );

  // Oscillator straight through; buffering only, no gating
  assign cpuDoubleClockOut = oscDoubleFreqIn;

  // Event terms shared by several fields
  assign busTake = hsel && htrans[1] && hready;
  assign cycStart = !addrStrobeN;
  assign swReset = q.wrPend && (q.wrAddr == csc_pkg::ADDR_PORTA)
                   && hwdata[csc_pkg::PORTA_SWRST_BIT];
  assign shutdownEvt = cycStart && decShutdown;
  assign resetEvt = swReset || (cycStart && decReset) || shutdownEvt
                    || (syncPins[csc_pkg::SY_BUS_RESET_DRIVE_IN] && !q.rstdrvPrev)
                    || (syncPins[csc_pkg::SY_KBDRC] && !q.kbdPrev);
  assign fpuClear = (cycStart && (decFpuClr || decFpuRst))
                    || syncPins[csc_pkg::SY_BUS_RESET_DRIVE_IN];
  assign fpuBusy = !syncPins[csc_pkg::SY_BUSY];
  assign fpuErr = !syncPins[csc_pkg::SY_ERR];

  // Next-state logic; every flop below runs on the loop-back clock
  always_comb
  begin
    d = q;
    d.rstdrvPrev = syncPins[csc_pkg::SY_BUS_RESET_DRIVE_IN];
    d.kbdPrev = syncPins[csc_pkg::SY_KBDRC];
    d.hldaPrev = holdAck;
    // Bus cycle tracking: strobe opens, ready input closes
    if (cycStart)
    begin
      d.cycActive = 1'b1;
      d.cycType = decType;
      d.slotCyc = slotCycle;
    end
    else if (!readyInN)
    begin
      d.cycActive = 1'b0;
    end
    // Merged ready; channel ready only counts on slot accesses
    d.readyOutN = !(dramReady
                    || (q.cycActive && q.slotCyc && !syncPins[csc_pkg::SY_CHRDY]));
    // Memory controls: masters drive them while the CPU is off the bus
    if (holdAck)
    begin
      d.memRdN = channelStatus1ReadN;
      d.ramWrN = channelStatus0WriteN;
    end
    else
    begin
      d.memRdN = !(q.cycActive && (q.cycType == csc_pkg::CSC_CYC_MEMRD
                                   || q.cycType == csc_pkg::CSC_CYC_CODE));
      d.ramWrN = !(q.cycActive && q.cycType == csc_pkg::CSC_CYC_MEMWR);
    end
    // Masters must not reach the protected upper regions
    d.upperInt = holdAck ? 3'h0 : upperAddr;
    d.holdReq = syncPins[csc_pkg::SY_DMA_HOLD_REQUEST_IN] || coupledRefreshReq;
    // Reset pulse; a new source retriggers the full length
    if (resetEvt)
      d.rstCnt = csc_pkg::RST_CNT_W'(csc_pkg::RESET_PULSE_CYC);
    else if (q.rstCnt != '0)
      d.rstCnt = q.rstCnt - 1'b1;
    // Busy latch: set wins, so an error in the clear cycle survives
    if (fpuErr)
      d.busyLatch = 1'b1;
    else if (fpuClear)
      d.busyLatch = 1'b0;
    // Forced request once the error outlives busy
    if (fpuErr && !fpuBusy)
      d.pereqForced = 1'b1;
    else if (cycStart && decFpuClr)
      d.pereqForced = 1'b0;
    d.busyOutN = !(fpuBusy || q.busyLatch);
    d.pereqOut = syncPins[csc_pkg::SY_PEREQ] || q.pereqForced;
    // Error held low through reset to pick the 32-bit interface
    d.errOutN = (d.rstCnt != '0) ? 1'b0 : syncPins[csc_pkg::SY_ERR];
    // Register bus data phase: writes land one cycle after the address
    d.wrPend = busTake && hwrite;
    if (busTake)
      d.wrAddr = haddr[7:0];
    if (q.wrPend)
    begin
      if (q.wrAddr == csc_pkg::ADDR_CTRL)
        d.ctrl = hwdata[7:0];
      else if (q.wrAddr == csc_pkg::ADDR_SLEEP)
        d.sleep = hwdata[7:0];
      else if (q.wrAddr == csc_pkg::ADDR_INTEN)
        d.inten = hwdata[csc_pkg::INT_W-1:0];
      else if (q.wrAddr == csc_pkg::ADDR_INTCLR)
        d.status = q.status & ~hwdata[csc_pkg::INT_W-1:0];
    end
    // Sticky events after the clear so a same-cycle set wins
    d.status[csc_pkg::INT_RESET] = d.status[csc_pkg::INT_RESET] || resetEvt;
    d.status[csc_pkg::INT_FPUERR] = d.status[csc_pkg::INT_FPUERR] || fpuErr;
    d.status[csc_pkg::INT_SHUTDOWN] = d.status[csc_pkg::INT_SHUTDOWN] || shutdownEvt;
    d.status[csc_pkg::INT_HOLD] = d.status[csc_pkg::INT_HOLD] || (holdAck && !q.hldaPrev);
    // Read data captured in the address phase, unmapped reads give zero
    if (busTake && !hwrite)
    begin
      if (haddr[7:0] == csc_pkg::ADDR_CTRL)
        d.rdata = {24'h000000, q.ctrl};
      else if (haddr[7:0] == csc_pkg::ADDR_SLEEP)
        d.rdata = {24'h000000, q.sleep};
      else if (haddr[7:0] == csc_pkg::ADDR_STATUS)
        d.rdata = {28'h0000000, q.status};
      else if (haddr[7:0] == csc_pkg::ADDR_INTEN)
        d.rdata = {28'h0000000, q.inten};
      else if (haddr[7:0] == csc_pkg::ADDR_STATE)
        d.rdata = {22'h000000, syncPins[csc_pkg::SY_MISS], q.cycType, q.cycActive,
                   q.pereqForced, q.busyLatch, q.holdReq, holdAck, q.rstCnt != '0};
      else
        d.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.ctrl <= csc_pkg::CTRL_RST;
      q.sleep <= csc_pkg::SLEEP_RST;
      q.cycType <= csc_pkg::CSC_CYC_INTA;
      q.readyOutN <= 1'b1;
      q.memRdN <= 1'b1;
      q.ramWrN <= 1'b1;
      q.busyOutN <= 1'b1;
      q.errOutN <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs; bus is zero-wait and always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign upperAddrInt = q.upperInt;
  assign readyOutN = q.readyOutN;
  assign holdRequest = q.holdReq;
  assign memReadN = q.memRdN;
  assign ramWriteN = q.ramWrN;
  assign cpuResetOut = (q.rstCnt != '0);
  assign cpuFpuErrorN = q.errOutN;
  assign cpuFpuBusyN = q.busyOutN;
  assign cpuOperandRequest = q.pereqOut;
  assign irq = |(q.status & q.inten);
  // Open drain: pulls low while sleep bit7 is 0; released in miss mode
  assign sleepOrMissPinOut = 1'b0;
  assign sleepOrMissPinOe = !q.ctrl[csc_pkg::CTRL_MISS_BIT]
                            && !q.sleep[csc_pkg::SLEEP_PIN_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence cycOpen;
    !addrStrobeN ##1 q.cycActive;
  endsequence

  chk_cycle_start: assert property (!addrStrobeN |-> ##1 q.cycType == $past(decType))
    else $error("cycle type not sampled at strobe");
  chk_strobe_opens: assert property (!addrStrobeN |-> cycOpen)
    else $error("strobe did not open a cycle");
  chk_ready_end: assert property (q.cycActive && addrStrobeN && !readyInN |=> !q.cycActive)
    else $error("ready input did not end cycle");
  chk_ready_merge: assert property (dramReady |=> !readyOutN)
    else $error("DRAM ready not merged");
  chk_ram_write: assert property (!ramWriteN && !$past(holdAck) |-> $past(q.cycType) == csc_pkg::CSC_CYC_MEMWR)
    else $error("RAM write outside write cycle");
  chk_hold_mem: assert property (holdAck |=> ramWriteN == $past(channelStatus0WriteN) && memReadN == $past(channelStatus1ReadN))
    else $error("memory controls not from channel");
  chk_upper_hold: assert property (holdAck |=> upperAddrInt == 3'h0)
    else $error("upper address not forced low");
  chk_hold_req: assert property (syncPins[csc_pkg::SY_DMA_HOLD_REQUEST_IN] |=> holdRequest)
    else $error("hold request missing");
  chk_reset_pulse: assert property ($rose(cpuResetOut) |-> ##(RST_HI_LAST) cpuResetOut)
    else $error("CPU reset pulse too short");
  chk_reset_error: assert property (cpuResetOut |-> !cpuFpuErrorN)
    else $error("error output high during reset");
  chk_busy_latch: assert property (q.busyLatch && !fpuClear |=> ##1 !cpuFpuBusyN)
    else $error("latched busy not driven");
  chk_pereq_force: assert property (fpuErr && !fpuBusy |=> ##1 cpuOperandRequest)
    else $error("operand request not forced");
  chk_miss_mode: assert property (q.ctrl[csc_pkg::CTRL_MISS_BIT] |-> !sleepOrMissPinOe)
    else $error("pin driven in miss mode");
endmodule
`default_nettype wire

// ===== sim/csc_far_side.sv
/*
  Far-side model: the CPU's hold handshake and the board's ready loop-back.
  Assumes the block's clock; slow selects a long hold answer.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_far_side (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  input wire logic holdRequest,
  input wire logic readyOutN,
  output logic holdAck,
  output logic readyInN
);
  logic [3:0] waitCnt;
  // Bus released after a short or long delay, then acknowledged
  always_ff @(posedge clk)
  begin
    if (!rst_b || !holdRequest)
    begin
      waitCnt <= 4'h0;
      holdAck <= 1'b0;
    end
    else if (waitCnt == (slow ? 4'h8 : 4'h1))
      holdAck <= 1'b1;
    else
      waitCnt <= waitCnt + 4'h1;
  end
  // No other ready source on the board, so the output comes straight back
  assign readyInN = readyOutN;
endmodule
`default_nettype wire

// ===== sim/csc_cpu_side_bench.sv
/*
  Self-checking bench: register bus, CPU cycles, hold, CPU reset sources,
  coprocessor relay and interrupt, against a small integer model.
  Assumes the far-side model and a pull-up on the sleep/miss pin.
*/
`timescale 1ns/100ps
`default_nettype none
module csc_cpu_side_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, oscDoubleFreqIn = 1'b0, slowAck = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, upperAddr = 3'h0, upperAddrInt;
  logic addrStrobeN = 1'b1, dataOrCode = 1'b0, memOrIo = 1'b0, writeOrRead = 1'b0;
  logic [3:0] byteEnN = 4'hF;
  logic [15:2] cpuAddr = 14'h0;
  logic dramReady = 1'b0, slotCycle = 1'b0, channelReadyN = 1'b1, dmaHoldRequestIn = 1'b0;
  logic coupledRefreshReq = 1'b0, channelStatus1ReadN = 1'b1, channelStatus0WriteN = 1'b1;
  logic busResetDriveIn = 1'b0, kbdResetCmdIn = 1'b0, fpuErrorInN = 1'b1, fpuBusyInN = 1'b1;
  logic fpuOperandRequestIn = 1'b0;
  logic hreadyout, hresp, cpuDoubleClockOut, readyOutN, holdRequest, memReadN, ramWriteN;
  logic cpuResetOut, cpuFpuErrorN, cpuFpuBusyN, cpuOperandRequest, sleepOrMissPinOut;
  logic sleepOrMissPinOe, irq, holdAck, readyInN;
  logic [31:0] hrdata;
  wire logic sleepPin = sleepOrMissPinOe ? sleepOrMissPinOut : 1'b1;
  int fail_count = 0;
  int checked = 0;
  int mdl [8];
  logic [15:0] lfsr = 16'h381D;

  csc_cpu_side u_dut (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .oscDoubleFreqIn, .cpuDoubleClockOut,
    .addrStrobeN, .dataOrCode, .memOrIo, .writeOrRead, .byteEnN, .cpuAddr, .upperAddr,
    .upperAddrInt, .readyInN, .readyOutN, .dramReady, .slotCycle, .channelReadyN, .holdAck,
    .holdRequest, .dmaHoldRequestIn, .coupledRefreshReq, .channelStatus1ReadN,
    .channelStatus0WriteN, .memReadN, .ramWriteN, .cpuResetOut, .busResetDriveIn,
    .kbdResetCmdIn, .fpuErrorInN, .fpuBusyInN, .fpuOperandRequestIn, .cpuFpuErrorN,
    .cpuFpuBusyN, .cpuOperandRequest, .sleepOrMissPinIn(sleepPin), .sleepOrMissPinOut,
    .sleepOrMissPinOe, .irq);
  csc_far_side u_far (.clk, .rst_b, .slow(slowAck), .holdRequest, .readyOutN, .holdAck,
    .readyInN);

  // 250 MHz clock; oscillator toggles off the same edges
  always #2 clk = ~clk;
  always @(posedge clk) oscDoubleFreqIn <= ~oscDoubleFreqIn;

  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic pick(input int w);
    case (w)
      0: return cpuResetOut;
      1: return holdRequest;
      2: return holdAck;
      3: return cpuFpuBusyN;
      default: return cpuOperandRequest;
    endcase
  endfunction
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chkVal(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a level; running out ends the run as a mismatch
  task automatic waitSig(input int w, input logic v);
    int n;
    for (n = 0; n < 40 && pick(w) !== v; n++)
      @(posedge clk);
    if (n == 40)
    begin
      fail_count++;
      $display("CHECK FAILED wait %0d expected %b seen %b", w, v, pick(w));
      complete_run();
    end
  endtask
  task automatic waitHready();
    int n;
    for (n = 0; n < 40; n++)
    begin
      @(posedge clk);
      if (hreadyout === 1'b1)
        break;
    end
    if (n == 40)
    begin
      fail_count++;
      $display("CHECK FAILED hready expected 1 seen %b", hreadyout);
      complete_run();
    end
  endtask
  // Single word: address phase held until hready, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    waitHready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitHready();
    r = hrdata;
  endtask
  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
    if (a == csc_pkg::ADDR_INTCLR)
      mdl[3] &= ~d;
    else if (a != csc_pkg::ADDR_PORTA)
      mdl[a[4:2]] = d;
  endtask
  task automatic regRd(input logic [7:0] a);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chkVal("register", mdl[a[4:2]], r);
  endtask
  // One CPU cycle; ready from DRAM, or from the channel for slot cycles
  task automatic cpuCycle(input logic [2:0] t, input logic [15:0] port, input logic [3:0] be,
                          input logic viaSlot);
    int n;
    logic sawWr;
    sawWr = 1'b0;
    @(posedge clk);
    {memOrIo, dataOrCode, writeOrRead} <= t;
    cpuAddr <= port[15:2];
    byteEnN <= be;
    slotCycle <= viaSlot;
    addrStrobeN <= 1'b0;
    @(posedge clk);
    addrStrobeN <= 1'b1;
    for (n = 0; n < 44 && (n < 2 || readyOutN !== 1'b0); n++)
    begin
      @(posedge clk);
      if (ramWriteN === 1'b0)
        sawWr = 1'b1;
      if (n == 1 && viaSlot)
        channelReadyN <= 1'b0;
      else if (n == 1)
        dramReady <= 1'b1;
    end
    chkVal("ready latency", viaSlot, n > 4);
    chkVal("ready seen", 1, n < 44);
    dramReady <= 1'b0;
    channelReadyN <= 1'b1;
    slotCycle <= 1'b0;
    repeat (3) @(posedge clk);
    chkVal("write strobe seen", t == 3'h7, sawWr);
    chkVal("write strobe idle", 1, ramWriteN);
  endtask
  task automatic resetPulse();
    int n;
    waitSig(0, 1'b1);
    for (n = 0; n < 40 && cpuResetOut === 1'b1; n++)
    begin
      chkVal("fpu error out", 0, cpuFpuErrorN);
      @(posedge clk);
    end
    chkVal("reset width", csc_pkg::RESET_PULSE_CYC, n);
  endtask

  // Main sequence
  initial
  begin
    foreach (mdl[i])
      mdl[i] = 0;
    mdl[1] = 32'h80;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 32; a += 4)
      if (a != 20 && a != 24)
        regRd(a[7:0]);
    chkVal("pin enable", 0, sleepOrMissPinOe);
    regWr(csc_pkg::ADDR_SLEEP, 32'h0);
    @(posedge clk);
    chkVal("pin level", 0, sleepPin);
    regWr(csc_pkg::ADDR_CTRL, 32'h1);
    @(posedge clk);
    chkVal("pin enable", 0, sleepOrMissPinOe);
    regRd(csc_pkg::ADDR_CTRL);
    ahb(1'b0, csc_pkg::ADDR_STATE, 32'h0, rd);
    chkVal("miss input", 1, rd[9]);
    regWr(csc_pkg::ADDR_CTRL, 32'h0);
    regWr(csc_pkg::ADDR_SLEEP, 32'h80);
    $display("test registers done");
    for (int t = 0; t < 8; t++)
    begin
      lfsr = nextRand(lfsr);
      cpuCycle(t[2:0], {lfsr[15:2], 2'h0}, 4'h0, t[0]);
      ahb(1'b0, csc_pkg::ADDR_STATE, 32'h0, rd);
      chkVal("cycle type", t, rd[8:6]);
    end
    $display("test cycles done");
    lfsr = nextRand(lfsr);
    upperAddr <= lfsr[2:0];
    slowAck <= lfsr[3];
    repeat (2) @(posedge clk);
    chkVal("upper copy", upperAddr, upperAddrInt);
    dmaHoldRequestIn <= 1'b1;
    waitSig(1, 1'b1);
    waitSig(2, 1'b1);
    channelStatus1ReadN <= 1'b0;
    repeat (2) @(posedge clk);
    chkVal("upper forced", 0, upperAddrInt);
    chkVal("hold read", 0, memReadN);
    channelStatus1ReadN <= 1'b1;
    channelStatus0WriteN <= 1'b0;
    repeat (2) @(posedge clk);
    chkVal("hold write", 0, ramWriteN);
    channelStatus0WriteN <= 1'b1;
    dmaHoldRequestIn <= 1'b0;
    waitSig(2, 1'b0);
    coupledRefreshReq <= 1'b1;
    waitSig(1, 1'b1);
    coupledRefreshReq <= 1'b0;
    waitSig(2, 1'b0);
    mdl[3] |= 8;
    $display("test hold done");
    for (int s = 0; s < 5; s++)
    begin
      fork
        resetPulse();
        case (s)
          0: regWr(csc_pkg::ADDR_PORTA, 32'h1);
          1: cpuCycle(3'h2, csc_pkg::PORT_RESET, 4'h7, 1'b0);
          2: cpuCycle(3'h1, 16'h0, csc_pkg::BE_SHUTDOWN, 1'b0);
          default:
          begin
            @(posedge clk);
            busResetDriveIn <= (s == 3);
            kbdResetCmdIn <= (s == 4);
            repeat (6) @(posedge clk);
            busResetDriveIn <= 1'b0;
            kbdResetCmdIn <= 1'b0;
          end
        endcase
      join
    end
    mdl[3] |= 5;
    regRd(csc_pkg::ADDR_STATUS);
    regWr(csc_pkg::ADDR_INTEN, 32'h1);
    @(posedge clk);
    chkVal("irq raised", 1, irq);
    regWr(csc_pkg::ADDR_INTCLR, 32'h1);
    @(posedge clk);
    chkVal("irq cleared", 0, irq);
    regRd(csc_pkg::ADDR_STATUS);
    $display("test reset done");
    fpuBusyInN <= 1'b0;
    waitSig(3, 1'b0);
    fpuErrorInN <= 1'b0;
    repeat (6) @(posedge clk);
    fpuBusyInN <= 1'b1;
    repeat (8) @(posedge clk);
    chkVal("busy latched", 0, cpuFpuBusyN);
    waitSig(4, 1'b1);
    fpuErrorInN <= 1'b1;
    // Let the synced error drop first, since a set beats a clear
    repeat (6) @(posedge clk);
    cpuCycle(3'h3, csc_pkg::PORT_FPU_RST, 4'hD, 1'b0);
    waitSig(3, 1'b1);
    chkVal("request forced", 1, cpuOperandRequest);
    cpuCycle(3'h3, csc_pkg::PORT_FPU_CLR, 4'hE, 1'b0);
    waitSig(4, 1'b0);
    fpuOperandRequestIn <= 1'b1;
    waitSig(4, 1'b1);
    mdl[3] |= 2;
    regRd(csc_pkg::ADDR_STATUS);
    $display("test coprocessor done");
    repeat (2)
    begin
      @(negedge clk);
      chkVal("clock out", oscDoubleFreqIn, cpuDoubleClockOut);
    end
    $display("test clock done");
    complete_run();
  end
endmodule
`default_nettype wire
